// [common/bcte_consts.vh]
`ifndef BCTE_CONSTS_VH
`define BCTE_CONSTS_VH

// Register byte offsets on the command port.
`define BCTE_OFS_OPCODE 8'h00
`define BCTE_OFS_OPERAND 8'h04
`define BCTE_OFS_ADDR 8'h08
`define BCTE_OFS_CTRL 8'h0C
`define BCTE_OFS_STATUS 8'h10
`define BCTE_OFS_RESULT 8'h14
`define BCTE_OFS_TARGET 8'h18

// Control and status field positions.
`define BCTE_CTRL_START 0
`define BCTE_ST_BUSY 0
`define BCTE_ST_DONE 1
`define BCTE_ST_BRANCH 2
`define BCTE_ST_BADOP 3
`define BCTE_ST_CC_LSB 4

// Reset values.
`define BCTE_RST_WORD 32'h0000_0000
`define BCTE_RST_OPCODE 8'h00
`define BCTE_RST_CC 4'h0

// Operation codes.
`define BCTE_OP_CLEAR_BIT 8'h76
`define BCTE_OP_INVERT_BIT 8'h77
`define BCTE_OP_CRC_TWELVE 8'h5E
`define BCTE_OP_CRC_SIXTEEN 8'h5F
`define BCTE_OP_TRANSLATE 8'hE7

// Condition codes C,V,G,L.
`define BCTE_CC_BIT_ONE 4'h2
`define BCTE_CC_BIT_ZERO 4'h0

// CRC feedback constants and iteration counts.
`define BCTE_CRC_TWELVE_OP_FEEDBACK 16'h0F01
`define BCTE_CRC_SIXTEEN_OP_FEEDBACK 16'hA001
`define BCTE_CRC_TWELVE_OP_STEPS 4'h6
`define BCTE_CRC_SIXTEEN_OP_STEPS 4'h8

// Operand sizes in bytes.
`define BCTE_BYTES_BIT 3'h1
`define BCTE_BYTES_HALF 3'h2
`define BCTE_BYTES_FULL 3'h4

`endif

// [hdl/bcte_exec.v]
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "bcte_consts.vh"

module bcte_exec (
  input wire mclk, // 200 MHz clock
  input wire sys_rst, // asynchronous reset, active high
  input wire [7:0] reg_addr, // register byte offset
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  output reg mem_req, // memory byte request, held until ack
  output reg mem_we, // memory request is a write
  output reg [31:0] mem_addr, // memory byte address
  output reg [7:0] mem_wdata, // memory write byte
  input wire [7:0] mem_rdata, // memory read byte, valid with ack
  input wire mem_ack, // memory completes request, one cycle
  output reg exec_busy, // operation in progress
  output reg exec_done, // operation finished, one cycle
  output reg cc_load, // condition code update, one cycle
  output reg [3:0] cond_code, // new condition code
  output reg operand_load, // operand register update, one cycle
  output reg [31:0] first_operand_register, // new operand register value
  output reg pc_load, // branch taken, one cycle
  output reg [31:0] program_counter // branch target
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_READ = 5'h02;
  localparam [4:0] S_EXEC = 5'h04;
  localparam [4:0] S_WRITE = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg [4:0] state_reg;
  reg [7:0] opcode_reg;
  reg [31:0] operand_reg;
  reg [31:0] addr_reg;
  reg [31:0] result_reg;
  reg [31:0] target_reg;
  reg [31:0] rbuf_reg;
  reg [15:0] wbuf_reg;
  reg [31:0] wr_addr_reg;
  reg [2:0] count_reg;
  reg table_phase_reg;
  reg done_reg;
  reg branch_reg;
  reg badop_reg;
  reg [3:0] cc_reg;

  wire start = reg_wr && (reg_addr == `BCTE_OFS_CTRL) && reg_wdata[`BCTE_CTRL_START] && (state_reg == S_IDLE);
  wire is_bit = (opcode_reg == `BCTE_OP_CLEAR_BIT) || (opcode_reg == `BCTE_OP_INVERT_BIT);
  wire is_crc = (opcode_reg == `BCTE_OP_CRC_TWELVE) || (opcode_reg == `BCTE_OP_CRC_SIXTEEN);
  wire is_char_translate_op = (opcode_reg == `BCTE_OP_TRANSLATE);
  wire [2:0] bit_pos = 3'h7 - operand_reg[2:0];
  wire old_bit = rbuf_reg[bit_pos];
  wire [15:0] crc_result = crc_step(operand_reg[7:0], rbuf_reg[15:0], opcode_reg == `BCTE_OP_CRC_SIXTEEN);
  wire [15:0] entry = rbuf_reg[15:0];

  // Runs the shift-register residual update for 6 or 8 data bits, lsb first.
  function [15:0] crc_step;
    input [7:0] data;
    input [15:0] residual;
    input wide;
    reg [15:0] res;
    reg [7:0] d;
    reg fb;
    reg [3:0] steps;
    reg [15:0] poly;
    integer i;
    begin
      res = residual;
      d = data;
      steps = wide ? `BCTE_CRC_SIXTEEN_OP_STEPS : `BCTE_CRC_TWELVE_OP_STEPS;
      poly = wide ? `BCTE_CRC_SIXTEEN_OP_FEEDBACK : `BCTE_CRC_TWELVE_OP_FEEDBACK;
      for (i = 0; i < 8; i = i + 1) begin
        if (i < steps) begin
          fb = d[0] ^ res[0];
          res = {1'b0, res[15:1]};
          if (fb) begin
            res = res ^ poly;
          end
          d = {1'b0, d[7:1]};
        end
      end
      crc_step = res;
    end
  endfunction

  // Command registers written from the register port, only while idle.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      opcode_reg <= `BCTE_RST_OPCODE;
      operand_reg <= `BCTE_RST_WORD;
      addr_reg <= `BCTE_RST_WORD;
    end else if (reg_wr && (state_reg == S_IDLE)) begin
      if (reg_addr == `BCTE_OFS_OPCODE) begin
        opcode_reg <= reg_wdata[7:0];
      end
      if (reg_addr == `BCTE_OFS_OPERAND) begin
        operand_reg <= reg_wdata;
      end
      if (reg_addr == `BCTE_OFS_ADDR) begin
        addr_reg <= reg_wdata;
      end
    end
  end

  // Read port, data stands in the cycle after the strobe only.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `BCTE_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        `BCTE_OFS_OPCODE: reg_rdata <= {24'h000000, opcode_reg};
        `BCTE_OFS_OPERAND: reg_rdata <= operand_reg;
        `BCTE_OFS_ADDR: reg_rdata <= addr_reg;
        `BCTE_OFS_STATUS: reg_rdata <= {24'h000000, cc_reg, badop_reg, branch_reg, done_reg, exec_busy};
        `BCTE_OFS_RESULT: reg_rdata <= result_reg;
        `BCTE_OFS_TARGET: reg_rdata <= target_reg;
        default: reg_rdata <= `BCTE_RST_WORD;
      endcase
    end else begin
      reg_rdata <= `BCTE_RST_WORD;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `BCTE_RST_WORD;
      mem_wdata <= 8'h00;
      rbuf_reg <= `BCTE_RST_WORD;
      wbuf_reg <= 16'h0000;
      wr_addr_reg <= `BCTE_RST_WORD;
      count_reg <= 3'h0;
      table_phase_reg <= 1'b0;
      result_reg <= `BCTE_RST_WORD;
      target_reg <= `BCTE_RST_WORD;
      done_reg <= 1'b0;
      branch_reg <= 1'b0;
      badop_reg <= 1'b0;
      cc_reg <= `BCTE_RST_CC;
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
      cc_load <= 1'b0;
      cond_code <= `BCTE_RST_CC;
      operand_load <= 1'b0;
      first_operand_register <= `BCTE_RST_WORD;
      pc_load <= 1'b0;
      program_counter <= `BCTE_RST_WORD;
    end else begin
      exec_done <= 1'b0;
      cc_load <= 1'b0;
      operand_load <= 1'b0;
      pc_load <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            exec_busy <= 1'b1;
            done_reg <= 1'b0;
            branch_reg <= 1'b0;
            badop_reg <= 1'b0;
            table_phase_reg <= 1'b0;
            result_reg <= operand_reg;
            if (is_bit) begin
              mem_addr <= addr_reg + {3'h0, operand_reg[31:3]};
              wr_addr_reg <= addr_reg + {3'h0, operand_reg[31:3]};
              count_reg <= `BCTE_BYTES_BIT;
              state_reg <= S_READ;
            end else if (is_crc) begin
              mem_addr <= addr_reg;
              wr_addr_reg <= addr_reg;
              count_reg <= `BCTE_BYTES_HALF;
              state_reg <= S_READ;
            end else if (is_char_translate_op) begin
              mem_addr <= addr_reg;
              count_reg <= `BCTE_BYTES_FULL;
              state_reg <= S_READ;
            end else begin
              badop_reg <= 1'b1;
              state_reg <= S_DONE;
            end
          end
        end
        S_READ: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            rbuf_reg <= {rbuf_reg[23:0], mem_rdata};
            mem_addr <= mem_addr + 32'h0000_0001;
            count_reg <= count_reg - 3'h1;
            if (count_reg == 3'h1) begin
              state_reg <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          mem_addr <= wr_addr_reg;
          if (is_bit) begin
            // Clear or invert only the selected bit.
            wbuf_reg[15:8] <= rbuf_reg[7:0] & ~(8'h01 << bit_pos);
            if (opcode_reg == `BCTE_OP_INVERT_BIT) begin
              wbuf_reg[15:8] <= rbuf_reg[7:0] ^ (8'h01 << bit_pos);
            end
            // Condition code from the old bit.
            cc_reg <= old_bit ? `BCTE_CC_BIT_ONE : `BCTE_CC_BIT_ZERO;
            cond_code <= old_bit ? `BCTE_CC_BIT_ONE : `BCTE_CC_BIT_ZERO;
            cc_load <= 1'b1;
            count_reg <= `BCTE_BYTES_BIT;
            state_reg <= S_WRITE;
          end else if (is_crc) begin
            // Residual write-back, no condition code change.
            wbuf_reg <= crc_result;
            count_reg <= `BCTE_BYTES_HALF;
            state_reg <= S_WRITE;
          end else if (!table_phase_reg) begin
            // Entry at base plus twice the character.
            mem_addr <= rbuf_reg + {23'h000000, operand_reg[7:0], 1'b0};
            table_phase_reg <= 1'b1;
            count_reg <= `BCTE_BYTES_HALF;
            state_reg <= S_READ;
          end else if (entry[15]) begin
            result_reg <= {operand_reg[31:8], entry[7:0]};
            first_operand_register <= {operand_reg[31:8], entry[7:0]};
            operand_load <= 1'b1;
            state_reg <= S_DONE;
          end else begin
            // Branch to the handler, condition code kept.
            target_reg <= {16'h0000, entry[14:0], 1'b0};
            program_counter <= {16'h0000, entry[14:0], 1'b0};
            pc_load <= 1'b1;
            branch_reg <= 1'b1;
            state_reg <= S_DONE;
          end
        end
        S_WRITE: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_wdata <= wbuf_reg[15:8];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            wbuf_reg <= {wbuf_reg[7:0], 8'h00};
            mem_addr <= mem_addr + 32'h0000_0001;
            count_reg <= count_reg - 3'h1;
            if (count_reg == 3'h1) begin
              state_reg <= S_DONE;
            end
          end
        end
        S_DONE: begin
          // Operand register is never written by CRC.
          exec_busy <= 1'b0;
          exec_done <= 1'b1;
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          mem_req <= 1'b0;
          exec_busy <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [sim/bcte_exec_assertions.sv]
`timescale 1ns/10ps
`include "bcte_consts.vh"

module bcte_exec_chk (
  input wire mclk, // clock
  input wire sys_rst, // reset
  input wire [7:0] reg_addr, // offset
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire mem_req, // mem request
  input wire mem_we, // mem write
  input wire [31:0] mem_addr, // mem address
  input wire [7:0] mem_wdata, // mem wdata
  input wire [7:0] mem_rdata, // mem rdata
  input wire mem_ack, // mem ack
  input wire exec_busy, // busy
  input wire exec_done, // done
  input wire cc_load, // cc pulse
  input wire [3:0] cond_code, // cc value
  input wire operand_load, // operand pulse
  input wire [31:0] first_operand_register, // operand
  input wire pc_load, // branch pulse
  input wire [31:0] program_counter // target
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_ack;
    mem_req && mem_ack;
  endsequence
  sequence s_start;
    reg_wr && reg_addr == `BCTE_OFS_CTRL && reg_wdata[0] && !exec_busy;
  endsequence
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  chk_req_gap: assert property (s_ack |=> !mem_req && !mem_ack)
    else $error("memory request not released after ack");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read");
  chk_done_pulse: assert property (exec_done |-> !exec_busy ##1 !exec_done)
    else $error("done not a single pulse");
  chk_busy_end: assert property ($fell(exec_busy) |-> exec_done)
    else $error("busy fell without done");
  chk_start_busy: assert property (s_start |=> exec_busy)
    else $error("start did not raise busy");
  chk_cc_code: assert property (cc_load |-> cond_code inside {`BCTE_CC_BIT_ONE, `BCTE_CC_BIT_ZERO})
    else $error("bad condition code");
  chk_pc_align: assert property (pc_load |-> program_counter[0] == 1'b0 && program_counter[31:16] == 16'h0)
    else $error("branch target not even");
  chk_tl_loads: assert property (pc_load || operand_load |-> !cc_load && !(pc_load && operand_load))
    else $error("translate outcome loads clash");
endmodule

bind bcte_exec bcte_exec_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .exec_busy(exec_busy),
  .exec_done(exec_done), .cc_load(cc_load), .cond_code(cond_code), .operand_load(operand_load),
  .first_operand_register(first_operand_register), .pc_load(pc_load), .program_counter(program_counter));

// [sim/bcte_mem_model.sv]
`timescale 1ns/10ps

module bcte_mem_model (
  input wire clk, // clock
  input wire rst, // reset
  input wire [1:0] lat, // extra wait cycles
  input wire mem_req, // request
  input wire mem_we, // write
  input wire [31:0] mem_addr, // address
  input wire [7:0] mem_wdata, // write byte
  output reg [7:0] mem_rdata, // read byte
  output reg mem_ack // ack pulse
);
  reg [7:0] mem [0:1023];
  reg [1:0] cnt_reg;

  // Read data toggles outside an ack so a stale byte is never mistaken for an answer.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt_reg <= 2'h0;
      mem_rdata <= 8'h5A;
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (cnt_reg == lat) begin
          mem_ack <= 1'b1;
          cnt_reg <= 2'h0;
          mem_rdata <= mem[mem_addr[9:0]];
          if (mem_we) begin
            mem[mem_addr[9:0]] <= mem_wdata;
          end
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/10ps
`include "bcte_consts.vh"

module testbench;
  reg mclk, sys_rst, reg_wr, reg_rd;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  reg [1:0] lat;
  wire [31:0] reg_rdata, mem_addr, first_operand_register, program_counter;
  wire [7:0] mem_rdata, mem_wdata;
  wire [3:0] cond_code;
  wire mem_req, mem_we, mem_ack, exec_busy, exec_done, cc_load, operand_load, pc_load;
  integer errors, tests_run, cc_cnt, c0, ol_cnt, pl_cnt, o0, p0;
  reg [31:0] st, res, opnd_seen, pc_seen;
  reg [3:0] cc_seen;

  bcte_exec dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .exec_busy(exec_busy),
    .exec_done(exec_done), .cc_load(cc_load), .cond_code(cond_code), .operand_load(operand_load),
    .first_operand_register(first_operand_register), .pc_load(pc_load), .program_counter(program_counter));
  bcte_mem_model u_mem (.clk(mclk), .rst(sys_rst), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (cc_load === 1'b1) begin
      cc_seen <= cond_code;
      cc_cnt <= cc_cnt + 1;
    end
    if (operand_load === 1'b1) begin
      opnd_seen <= first_operand_register;
      ol_cnt <= ol_cnt + 1;
    end
    if (pc_load === 1'b1) begin
      pc_seen <= program_counter;
      pl_cnt <= pl_cnt + 1;
    end
  end

  task check(input string nm, input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask

  task run(input [7:0] op, input [31:0] opnd, input [31:0] adr);
    integer n;
    begin
      c0 = cc_cnt;
      o0 = ol_cnt;
      p0 = pl_cnt;
      wr(`BCTE_OFS_OPCODE, {24'h0, op});
      wr(`BCTE_OFS_OPERAND, opnd);
      wr(`BCTE_OFS_ADDR, adr);
      wr(`BCTE_OFS_CTRL, 32'h1);
      n = 0;
      while (exec_done !== 1'b1 && n < 400) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      check("done", exec_done, 1);
      rd(`BCTE_OFS_STATUS, st);
      rd(`BCTE_OFS_RESULT, res);
    end
  endtask

  task t_bit(input [7:0] op, input [31:0] off, input [15:0] e, input [3:0] ec);
    begin
      run(op, off, 32'h40);
      check("bit array", {u_mem.mem[10'h40], u_mem.mem[10'h41]}, e);
      check("bit cc count", cc_cnt - c0, 1);
      check("bit cc", cc_seen, ec);
      check("bit offset", res, off);
      check("bit operand load", ol_cnt - o0, 0);
    end
  endtask

  function [15:0] crc_ref(input [7:0] d, input [15:0] r, input w);
    integer i;
    reg b;
    begin
      crc_ref = r;
      for (i = 0; i < (w ? 8 : 6); i = i + 1) begin
        b = d[i] ^ crc_ref[0];
        crc_ref = crc_ref >> 1;
        if (b) crc_ref = crc_ref ^ (w ? `BCTE_CRC_SIXTEEN_OP_FEEDBACK : `BCTE_CRC_TWELVE_OP_FEEDBACK);
      end
    end
  endfunction

  task t_crc(input [7:0] op, input [31:0] ch, input [9:0] a, input [15:0] old, input w);
    begin
      u_mem.mem[a] = old[15:8];
      u_mem.mem[a + 10'h1] = old[7:0];
      run(op, ch, {22'h0, a});
      check("crc residual", {u_mem.mem[a], u_mem.mem[a + 10'h1]}, crc_ref(ch[7:0], old, w));
      check("crc operand", res, ch);
      check("crc operand load", ol_cnt - o0, 0);
      check("crc cc", cc_cnt, c0);
    end
  endtask

  task t_tl(input [31:0] opnd, input [31:0] e, input hit);
    begin
      run(`BCTE_OP_TRANSLATE, opnd, 32'h80);
      check("tl result", hit ? opnd_seen : pc_seen, e);
      check("tl branch", st[2], !hit);
      check("tl operand load", ol_cnt - o0, hit);
      check("tl branch load", pl_cnt - p0, !hit);
      check("tl cc", cc_cnt, c0);
    end
  endtask

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #200000;
    errors = errors + 1;
    final_report;
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, lat} = {1'b1, 44'h0};
    {errors, tests_run, cc_cnt, ol_cnt, pl_cnt} = 0;
    {u_mem.mem[10'h40], u_mem.mem[10'h41]} = 16'h3143;
    // Table pointer sits on a fullword boundary.
    {u_mem.mem[10'h80], u_mem.mem[10'h81], u_mem.mem[10'h82], u_mem.mem[10'h83]} = 32'h00000100;
    {u_mem.mem[10'h104], u_mem.mem[10'h105], u_mem.mem[10'h10A], u_mem.mem[10'h10B]} = 32'h80520432;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`BCTE_OFS_STATUS, st);
    check("status reset", st, 0);
    rd(8'h1C, st);
    check("unmapped", st, 0);
    t_bit(`BCTE_OP_CLEAR_BIT, 32'd3, 16'h2143, `BCTE_CC_BIT_ONE);
    t_bit(`BCTE_OP_INVERT_BIT, 32'd11, 16'h2153, `BCTE_CC_BIT_ZERO);
    t_bit(`BCTE_OP_INVERT_BIT, 32'd2, 16'h0153, `BCTE_CC_BIT_ONE);
    // Residuals sit on halfword boundaries; the second run uses a slow memory.
    t_crc(`BCTE_OP_CRC_SIXTEEN, 32'hFFFFFFA5, 10'h060, 16'h1234, 1'b1);
    lat <= 2'h2;
    t_crc(`BCTE_OP_CRC_TWELVE, 32'h000000C3, 10'h062, 16'h0ABC, 1'b0);
    lat <= 2'h0;
    t_tl(32'hABCDEF02, 32'hABCDEF52, 1'b1);
    t_tl(32'h00000005, 32'h00000864, 1'b0);
    run(8'h33, 32'h0, 32'h40);
    check("bad opcode", {st[3], u_mem.mem[10'h40]}, 9'h101);
    final_report;
  end
endmodule
